// File: hdl/spb_pkg.sv
// Constants shared by the sector protection block and its helpers.
// Assumes a 100 MHz pclk and a 24-bit flash byte address.
package spb_pkg;
	// Group map
	localparam int GROUPS = 286;
	localparam int GW = 9;
	localparam int AW = 24;
	localparam logic [7:0] TOP_SMALL_BLK = 8'hfe;
	localparam logic [GW-1:0] SMALL_BASE = 9'h0fe;
	localparam logic [7:0] BOT_SMALL_BLKS = 8'h02;
	localparam logic [GW-1:0] BOT_SHIFT = 9'h01e;

	// Register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_PWD_LO = 8'h08;
	localparam logic [7:0] OFS_PWD_HI = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CONFIG = 8'h14;

	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 4;
	localparam int CMD_DYB_VAL = 8;

	// Command codes
	localparam logic [3:0] OP_PPB_PROG = 4'h1;
	localparam logic [3:0] OP_PPB_ERASE = 4'h2;
	localparam logic [3:0] OP_DYB_WRITE = 4'h3;
	localparam logic [3:0] OP_LOCK_CLEAR = 4'h4;
	localparam logic [3:0] OP_UNLOCK = 4'h5;
	localparam logic [3:0] OP_SW_RESET = 4'h6;
	localparam logic [3:0] OP_PPB_READ = 4'h7;
	localparam logic [3:0] OP_DYB_READ = 4'h8;
	localparam logic [3:0] OP_CHECK = 4'h9;

	// Status register bits
	localparam int ST_BUSY = 0;
	localparam int ST_P_ERR = 1;
	localparam int ST_PROT_E = 2;
	localparam int ST_GUARD = 3;
	localparam int ST_PWD_MODE = 4;
	localparam int ST_RD_BIT = 5;
	localparam int ST_PROTECTED = 6;
	localparam int ST_RD_BLOCK = 7;

	// Config register bits
	localparam int CFG_SIDE = 0;

	// Timing
	localparam int CLK_MHZ = 100;
	localparam int PPB_PROG_US = 200;
	localparam int PPB_ERASE_US = 1000;
	localparam int UNLOCK_FAIL_US = 100;
	localparam int TW = 24;
endpackage

// File: hdl/spb_protect.sv
// Sector and block protection logic: persistent bits, dynamic bits and
// the guard bit over the persistent bits, driven by commands over APB.
// Assumes presetn is power-up reset and hw_reset_n is an async pin.
// What this block does
// - Bottom-side select zero: 64K blocks, then 4K sectors of blocks 254, 255
// - One persistent bit per group, programmed singly, erased together
// - Programming clears a persistent bit; erase sets all to one
// - Erase preparation happens internally, no host involvement
// - Program lasts one page time, erase one sector-erase time
// - Busy status visible while a persistent operation runs
// - Array reads refused while a persistent bit is programmed
// - Erase of persistent bits takes no address
// - Persistent bits start erased at one
// - One dynamic bit per group, written freely to zero or one
// - Dynamic bit matters only where persistent bit is one
// - Single guard bit: zero freezes persistent bits, one allows change
// - Persistent program or erase fails while guard is zero
// - Persistent mode: guard set to one at power-up and hardware reset
// - Persistent mode: no command sets guard back to one
// - Password mode: guard cleared at power-up and hardware reset
// - Password mode: only a matching unlock sets guard
// - Group protected when either its persistent or dynamic bit is zero
// - Lock-clear command writes guard to zero
// - Unlock compares 64-bit value with hidden password, sets guard on match
// - Software reset leaves the guard unchanged
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module spb_protect
	import spb_pkg::*;
#(
	parameter int PROG_CYCLES = PPB_PROG_US * CLK_MHZ,
	parameter int ERASE_CYCLES = PPB_ERASE_US * CLK_MHZ,
	parameter int UNLOCK_FAIL_CYCLES = UNLOCK_FAIL_US * CLK_MHZ
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device pins and straps
	input wire logic hw_reset_n,
	input wire logic password_mode,
	input wire logic [63:0] hidden_password,
	// Status to the array controller
	output logic busy,
	output logic array_read_block,
	output logic persistent_bits_guard
);
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_PROG,
		PH_ERASE,
		PH_UNLOCK
	} spb_phase_t;

	typedef struct packed {
		logic [GROUPS-1:0] persistent_protect_bit;
		logic [GROUPS-1:0] dynamic_protect_bit;
		logic guard;
		logic small_sector_side_select;
		logic p_err;
		logic prot_e;
		logic rd_bit;
		logic protected_flag;
		logic busy;
		logic rd_block;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [AW-1:0] addr;
		logic [63:0] pwd;
		spb_phase_t phase;
		logic [GW-1:0] grp;
	} spb_state_t;

	spb_state_t s_r;
	spb_state_t s_nxt;

	logic hw_rst_n_s;
	logic pwd_mode_s;
	logic tim_load;
	logic tim_abort;
	logic [TW-1:0] tim_val;
	logic tim_done;

	// Pins cross into pclk through two flops
	spb_sync2 #(.W(1), .INIT(1'b1)) u_sync_rst (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d(hw_reset_n),
		.q(hw_rst_n_s)
	);

	spb_sync2 #(.W(1), .INIT(1'b0)) u_sync_mode (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d(password_mode),
		.q(pwd_mode_s)
	);

	spb_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.load(tim_load),
		.abort(tim_abort),
		.load_val(tim_val),
		.done(tim_done)
	);

	function automatic logic [GW-1:0] group_of(input logic [AW-1:0] a, input logic side);
		logic [7:0] blk;
		logic [GW-1:0] idx;
		blk = a[23:16];
		if (!side) begin
			if (blk >= TOP_SMALL_BLK) begin
				idx = SMALL_BASE + {4'h0, a[16:12]};
			end else begin
				idx = {1'b0, blk};
			end
		end else begin
			if (blk < BOT_SMALL_BLKS) begin
				idx = {4'h0, a[16:12]};
			end else begin
				idx = {1'b0, blk} + BOT_SHIFT;
			end
		end
		return idx;
	endfunction

	logic setup;
	logic access;
	logic mapped;
	logic [GW-1:0] cur_grp;
	logic [CMD_OP_W-1:0] op;

	always_comb begin
		setup = psel && !penable;
		access = psel && penable && s_r.pready;
		mapped = (paddr == OFS_CMD) || (paddr == OFS_ADDR) || (paddr == OFS_PWD_LO)
			|| (paddr == OFS_PWD_HI) || (paddr == OFS_STATUS) || (paddr == OFS_CONFIG);
		cur_grp = group_of(s_r.addr, s_r.small_sector_side_select);
		op = pwdata[CMD_OP_LSB +: CMD_OP_W];
	end

	always_comb begin
		s_nxt = s_r;
		tim_load = 1'b0;
		tim_abort = 1'b0;
		tim_val = '0;
		if (ce) begin
			// Zero-wait APB: answer decided in the setup cycle
			s_nxt.pready = setup;
			s_nxt.pslverr = setup && !mapped;
			if (setup) begin
				s_nxt.prdata = '0;
				if (!pwrite) begin
					unique case (paddr)
						OFS_ADDR: begin
							s_nxt.prdata[AW-1:0] = s_r.addr;
						end
						OFS_STATUS: begin
							s_nxt.prdata[ST_BUSY] = s_r.busy;
							s_nxt.prdata[ST_P_ERR] = s_r.p_err;
							s_nxt.prdata[ST_PROT_E] = s_r.prot_e;
							s_nxt.prdata[ST_GUARD] = s_r.guard;
							s_nxt.prdata[ST_PWD_MODE] = pwd_mode_s;
							s_nxt.prdata[ST_RD_BIT] = s_r.rd_bit;
							s_nxt.prdata[ST_PROTECTED] = s_r.protected_flag;
							s_nxt.prdata[ST_RD_BLOCK] = s_r.rd_block;
						end
						OFS_CONFIG: begin
							s_nxt.prdata[CFG_SIDE] = s_r.small_sector_side_select;
						end
						default: begin
							s_nxt.prdata = '0;
						end
					endcase
				end
			end

			// Register writes; the password words are write-only
			if (access && pwrite && !s_r.pslverr) begin
				unique case (paddr)
					OFS_ADDR: begin
						s_nxt.addr = pwdata[AW-1:0];
					end
					OFS_PWD_LO: begin
						s_nxt.pwd[31:0] = pwdata;
					end
					OFS_PWD_HI: begin
						s_nxt.pwd[63:32] = pwdata;
					end
					OFS_STATUS: begin
						// Write one to clear; a hardware set later in this cycle wins
						if (pwdata[ST_P_ERR]) begin
							s_nxt.p_err = 1'b0;
						end
						if (pwdata[ST_PROT_E]) begin
							s_nxt.prot_e = 1'b0;
						end
					end
					OFS_CONFIG: begin
						s_nxt.small_sector_side_select = pwdata[CFG_SIDE];
					end
					OFS_CMD: begin
						// Commands arriving while busy are dropped, as a real part ignores them
						if (!s_r.busy && hw_rst_n_s) begin
							unique case (op)
								OP_PPB_PROG: begin
									if (!s_r.guard) begin
										s_nxt.p_err = 1'b1;
										s_nxt.prot_e = 1'b1;
									end else begin
										s_nxt.grp = cur_grp;
										s_nxt.phase = PH_PROG;
										s_nxt.busy = 1'b1;
										s_nxt.rd_block = 1'b1;
										tim_load = 1'b1;
										tim_val = TW'(PROG_CYCLES);
									end
								end
								OP_PPB_ERASE: begin
									if (!s_r.guard) begin
										s_nxt.p_err = 1'b1;
										s_nxt.prot_e = 1'b1;
									end else begin
										s_nxt.phase = PH_ERASE;
										s_nxt.busy = 1'b1;
										tim_load = 1'b1;
										tim_val = TW'(ERASE_CYCLES);
									end
								end
								OP_DYB_WRITE: begin
									s_nxt.dynamic_protect_bit[cur_grp] = pwdata[CMD_DYB_VAL];
								end
								OP_LOCK_CLEAR: begin
									s_nxt.guard = 1'b0;
								end
								OP_UNLOCK: begin
									// Persistent mode has no command that sets the guard
									if (pwd_mode_s) begin
										if (s_r.pwd == hidden_password) begin
											s_nxt.guard = 1'b1;
										end else begin
											// Failed tries are slowed to defeat a search
											s_nxt.phase = PH_UNLOCK;
											s_nxt.busy = 1'b1;
											tim_load = 1'b1;
											tim_val = TW'(UNLOCK_FAIL_CYCLES);
										end
									end
								end
								OP_SW_RESET: begin
									s_nxt.dynamic_protect_bit = '1;
								end
								OP_PPB_READ: begin
									s_nxt.rd_bit = s_r.persistent_protect_bit[cur_grp];
								end
								OP_DYB_READ: begin
									s_nxt.rd_bit = s_r.dynamic_protect_bit[cur_grp];
								end
								OP_CHECK: begin
									s_nxt.protected_flag = !s_r.persistent_protect_bit[cur_grp]
										|| !s_r.dynamic_protect_bit[cur_grp];
								end
								default: begin
									s_nxt.p_err = 1'b1;
								end
							endcase
						end
					end
					default: begin
						s_nxt.addr = s_r.addr;
					end
				endcase
			end

			// Completion of timed operations
			if (tim_done) begin
				unique case (s_r.phase)
					PH_PROG: begin
						s_nxt.persistent_protect_bit[s_r.grp] = 1'b0;
						s_nxt.rd_block = 1'b0;
					end
					PH_ERASE: begin
						// Preprogram and verify are folded into this one interval
						s_nxt.persistent_protect_bit = '1;
					end
					PH_UNLOCK: begin
						s_nxt.p_err = 1'b1;
						s_nxt.prot_e = 1'b1;
					end
					PH_IDLE: begin
						s_nxt.phase = PH_IDLE;
					end
				endcase
				s_nxt.phase = PH_IDLE;
				s_nxt.busy = 1'b0;
			end

			// Hardware reset pin; an interrupted program leaves the bit untouched
			if (!hw_rst_n_s) begin
				s_nxt.guard = !pwd_mode_s;
				s_nxt.dynamic_protect_bit = '1;
				s_nxt.phase = PH_IDLE;
				s_nxt.busy = 1'b0;
				s_nxt.rd_block = 1'b0;
				tim_abort = 1'b1;
			end
		end
	end

	// Power-up reset cannot see the mode strap; guard follows it until the sync is full
	// Password mode shows guard one for the first three cycles only
	logic [2:0] mode_settled_r;
	logic [2:0] mode_settled_nxt;
	logic guard_fix;

	always_comb begin
		mode_settled_nxt = mode_settled_r;
		if (ce) begin
			mode_settled_nxt = 3'({mode_settled_r, 1'b1});
		end
		guard_fix = ce && !(&mode_settled_r);
	end

	spb_state_t s_fix;

	always_comb begin
		s_fix = s_nxt;
		// Persistent mode keeps its reset value, so an early lock clear survives
		if (guard_fix) begin
			s_fix.guard = s_nxt.guard && !pwd_mode_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{persistent_protect_bit: '1, dynamic_protect_bit: '1, guard: 1'b1,
				phase: PH_IDLE, default: '0};
			mode_settled_r <= '0;
		end else begin
			s_r <= s_fix;
			mode_settled_r <= mode_settled_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign busy = s_r.busy;
	assign array_read_block = s_r.rd_block;
	assign persistent_bits_guard = s_r.guard;
endmodule

// File: hdl/spb_sync2.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes d comes from outside the pclk domain.
`timescale 1ns/1ps
module spb_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Level in and out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} spb_sync_t;

	spb_sync_t s_r;
	spb_sync_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (ce) begin
			s_nxt.meta = d;
			s_nxt.stable = s_r.meta;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{meta: INIT, stable: INIT};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.stable;
endmodule

// File: hdl/spb_timer.sv
// Down counter that times internal persistent-bit operations.
// Assumes load is a one-cycle pulse and load_val is at least one.
`timescale 1ns/1ps
module spb_timer
	import spb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Control
	input wire logic load,
	input wire logic abort,
	input wire logic [TW-1:0] load_val,
	// Completion
	output logic done
);
	typedef struct packed {
		logic [TW-1:0] cnt;
		logic run;
		logic done;
	} spb_tim_t;

	spb_tim_t t_r;
	spb_tim_t t_nxt;

	always_comb begin
		t_nxt = t_r;
		if (ce) begin
			t_nxt.done = 1'b0;
			if (abort) begin
				t_nxt.run = 1'b0;
			end else if (load) begin
				t_nxt.cnt = load_val;
				t_nxt.run = 1'b1;
			end else if (t_r.run) begin
				if (t_r.cnt == TW'(1)) begin
					t_nxt.run = 1'b0;
					t_nxt.done = 1'b1;
				end
				t_nxt.cnt = t_r.cnt - TW'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_r <= '0;
		end else begin
			t_r <= t_nxt;
		end
	end

	assign done = t_r.done;
endmodule

// File: verification/spb_host.sv
// Host controller model: APB master issuing protection commands.
// Assumes the slave answers in its own time; the bench bounds hangs.
`timescale 1ns/1ps
module spb_host (
	// Clock
	input wire logic pclk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Request held until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
endmodule

// File: verification/spb_protect_properties.sv
// Port checker for the sector protection block.
// Assumes ce drops only while idle and password_mode changes only under presetn.
`timescale 1ns/1ps
module spb_protect_properties #(
	parameter int PROG_CYCLES = 5,
	parameter int ERASE_CYCLES = 8,
	parameter int UNLOCK_FAIL_CYCLES = 4
) (
	// Watched ports
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic hw_reset_n,
	input wire logic password_mode,
	input wire logic busy,
	input wire logic array_read_block,
	input wire logic persistent_bits_guard
);
	localparam int BUSY_MAX = (ERASE_CYCLES > UNLOCK_FAIL_CYCLES ? ERASE_CYCLES :
		UNLOCK_FAIL_CYCLES) + 1;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Lengths of the current windows
	logic [31:0] blk_cnt_r;
	logic [31:0] busy_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blk_cnt_r <= '0;
			busy_cnt_r <= '0;
		end else begin
			blk_cnt_r <= array_read_block ? blk_cnt_r + 1 : '0;
			busy_cnt_r <= busy ? busy_cnt_r + 1 : '0;
		end
	end
	a_setup_gets_ready: assert property (psel && !penable && ce |=> pready)
		else $error("no ready after setup");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_block_means_busy: assert property (array_read_block |-> busy)
		else $error("read block without busy");
	a_block_fall_busy: assert property ($fell(array_read_block) |-> $fell(busy))
		else $error("busy and read block apart");
	a_prog_length: assert property ($fell(array_read_block) |-> blk_cnt_r == PROG_CYCLES + 1)
		else $error("program window length wrong");
	a_busy_bounded: assert property (busy_cnt_r <= BUSY_MAX)
		else $error("busy too long");
	a_guard_hw_reset: assert property (!hw_reset_n [*5] |-> persistent_bits_guard == !password_mode)
		else $error("guard wrong under hardware reset");
	a_guard_no_rise: assert property ($rose(persistent_bits_guard) && !password_mode |->
		!$past(hw_reset_n, 2) || !$past(hw_reset_n, 3) || !$past(hw_reset_n, 4))
		else $error("guard set without hardware reset");
	a_guard_frozen_op: assert property (!password_mode && !persistent_bits_guard |=> !$rose(busy))
		else $error("persistent operation ran while frozen");
	c_prog: cover property ($fell(array_read_block));
	c_guard_clear: cover property ($fell(persistent_bits_guard));
	c_slverr: cover property (pslverr);
endmodule
bind spb_protect spb_protect_properties #(.PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES), .UNLOCK_FAIL_CYCLES(UNLOCK_FAIL_CYCLES)) u_props (.pclk,
	.presetn, .ce, .psel, .penable, .pready, .pslverr, .hw_reset_n, .password_mode, .busy,
	.array_read_block, .persistent_bits_guard);

// File: verification/testbench.sv
// Self-checking bench for the sector protection block.
// Assumes spb_host drives APB; ce drops only while the block is idle.
`timescale 1ns/1ps
module testbench;
	import spb_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic hw_reset_n = 1'b1;
	logic ce = 1'b1;
	logic password_mode = 1'b0;
	logic [63:0] pwd = 64'h0123456789abcdef;
	logic psel, penable, pwrite, pready, pslverr, busy, arb, guard, err, saw;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, st, rdv;
	logic [31:0] seed = 32'h00000044;
	logic ppb_m [GROUPS];
	logic dyb_m [GROUPS];
	int mismatches = 0;
	int compares = 0;
	always #5 pclk = ~pclk;
	// Short timer counts keep the run brief
	spb_protect #(.PROG_CYCLES(5), .ERASE_CYCLES(8), .UNLOCK_FAIL_CYCLES(4)) u_spb_protect (
		.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .hw_reset_n, .password_mode, .hidden_password(pwd), .busy,
		.array_read_block(arb), .persistent_bits_guard(guard));
	spb_host u_spb_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [23:0] gaddr(int g);
		return (g < 254) ? 24'(g) << 16 : 24'hfe0000 + (24'(g - 254) << 12);
	endfunction
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		u_spb_host.xfer(1'b1, a, d, rdv, err);
	endtask
	// One command, then wait out busy and read status
	task automatic op(logic [3:0] c, logic [23:0] a, logic v);
		int n;
		wr(OFS_ADDR, {8'h00, a});
		wr(OFS_CMD, {23'h0, v, 4'h0, c});
		saw = 1'b0;
		n = 0;
		repeat (2) @(posedge pclk);
		while (busy !== 1'b0 && n < 300) begin
			saw |= arb;
			n++;
			@(posedge pclk);
		end
		chk("busy end", {31'h0, busy}, 32'h0);
		u_spb_host.xfer(1'b0, OFS_STATUS, 32'h0, st, err);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		test_done();
	end
	initial begin
		int g;
		int tbl[4];
		logic [31:0] r;
		tbl = '{0, 253, 254, 285};
		for (int i = 0; i < GROUPS; i++) begin
			ppb_m[i] = 1'b1;
			dyb_m[i] = 1'b1;
		end
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		u_spb_host.xfer(1'b0, 8'h18, 32'h0, rdv, err);
		chk("unmapped", {err, rdv[30:0]}, 32'h80000000);
		u_spb_host.xfer(1'b0, OFS_CONFIG, 32'h0, rdv, err);
		chk("side", rdv, 32'h0);
		for (int i = 0; i < 10; i++) begin
			g = (i < 4) ? tbl[i] : int'(xs() % 286);
			r = xs() | 32'(i == 2) * 3;
			op(OP_PPB_READ, gaddr(g), 1'b0);
			chk("ppb", {31'h0, st[ST_RD_BIT]}, {31'h0, ppb_m[g]});
			op(OP_DYB_WRITE, gaddr(g), r[0]);
			dyb_m[g] = r[0];
			if (r[1]) begin
				op(OP_PPB_PROG, gaddr(g), 1'b0);
				chk("blk", {31'h0, saw}, 32'h1);
				ppb_m[g] = 1'b0;
			end
			op(OP_DYB_READ, gaddr(g), 1'b0);
			chk("dyb", {31'h0, st[ST_RD_BIT]}, {31'h0, dyb_m[g]});
			op(OP_CHECK, gaddr(g) | (r[27:4] & (g < 254 ? 24'h00ffff : 24'h000fff)), 1'b0);
			chk("prot", {31'h0, st[ST_PROTECTED]}, {31'h0, !(ppb_m[g] && dyb_m[g])});
		end
		wr(OFS_CONFIG, 32'h1);
		op(OP_DYB_WRITE, 24'h001000, !dyb_m[1]);
		dyb_m[1] = !dyb_m[1];
		wr(OFS_CONFIG, 32'h0);
		op(OP_DYB_READ, gaddr(1), 1'b0);
		chk("side map", {31'h0, st[ST_RD_BIT]}, {31'h0, dyb_m[1]});
		op(OP_LOCK_CLEAR, 24'h0, 1'b0);
		chk("guard", {31'h0, guard}, 32'h0);
		ce <= 1'b0;
		hw_reset_n <= 1'b0;
		repeat (3) @(posedge pclk);
		hw_reset_n <= 1'b1;
		repeat (2) @(posedge pclk);
		ce <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("ce freeze", {31'h0, guard}, 32'h0);
		op(OP_PPB_ERASE, 24'h0, 1'b0);
		chk("erase err", st & 32'h6, 32'h6);
		op(OP_PPB_READ, gaddr(254), 1'b0);
		chk("ppb kept", {31'h0, st[ST_RD_BIT]}, 32'h0);
		op(OP_UNLOCK, 24'h0, 1'b0);
		op(OP_SW_RESET, 24'h0, 1'b0);
		chk("guard sw", {31'h0, guard}, 32'h0);
		hw_reset_n <= 1'b0;
		repeat (6) @(posedge pclk);
		hw_reset_n <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("guard hw", {31'h0, guard}, 32'h1);
		op(OP_PPB_ERASE, 24'h0, 1'b0);
		op(OP_PPB_READ, gaddr(254), 1'b0);
		chk("erased", {31'h0, st[ST_RD_BIT]}, 32'h1);
		presetn <= 1'b0;
		password_mode <= 1'b1;
		pwd <= {xs(), xs()};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("guard up", {31'h0, guard}, 32'h0);
		hw_reset_n <= 1'b0;
		repeat (6) @(posedge pclk);
		hw_reset_n <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("guard pw", {31'h0, guard}, 32'h0);
		wr(OFS_PWD_LO, pwd[31:0] ^ 32'h1);
		wr(OFS_PWD_HI, pwd[63:32]);
		op(OP_UNLOCK, 24'h0, 1'b0);
		chk("bad pw", st & 32'h1e, 32'h16);
		wr(OFS_PWD_LO, pwd[31:0]);
		op(OP_UNLOCK, 24'h0, 1'b0);
		chk("good pw", {31'h0, guard}, 32'h1);
		test_done();
	end
endmodule
